//--- src/ict_pkg.sv
package ict_pkg;
    // Instruction lengths in bytes.
    localparam logic [1:0] LEN_1 = 2'h1;
    localparam logic [1:0] LEN_2 = 2'h2;
    localparam logic [1:0] LEN_3 = 2'h3;
    // Instruction durations in system clock cycles.
    localparam logic [2:0] CYC_1 = 3'h1;
    localparam logic [2:0] CYC_2 = 3'h2;
    localparam logic [2:0] CYC_3 = 3'h3;
    localparam logic [2:0] CYC_4 = 3'h4;
    localparam logic [2:0] CYC_5 = 3'h5;
    localparam logic [2:0] CYC_EXTRA = 3'h1;
    localparam logic [2:0] CNT_LAST = 3'h1;
    localparam logic [2:0] SINCE_MAX = 3'h7;
    // Opcode masks for register, pointer and page forms.
    localparam logic [7:0] M_REG = 8'hf8;
    localparam logic [7:0] M_PTR = 8'hfe;
    localparam logic [7:0] M_PAGE = 8'h1f;
    // Opcode encodings; ranged forms give the lowest member.
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_SPARE = 8'ha5;
    localparam logic [7:0] OP_MOV_REG_A = 8'hf8;
    localparam logic [7:0] OP_MOV_REG_DIR = 8'ha8;
    localparam logic [7:0] OP_MOV_REG_IMM = 8'h78;
    localparam logic [7:0] OP_MOV_A_IMM = 8'h74;
    localparam logic [7:0] OP_MOV_DIR_A = 8'hf5;
    localparam logic [7:0] OP_MOV_DIR_REG = 8'h88;
    localparam logic [7:0] OP_MOV_DIR_DIR = 8'h85;
    localparam logic [7:0] OP_MOV_DIR_IND = 8'h86;
    localparam logic [7:0] OP_MOV_DIR_IMM = 8'h75;
    localparam logic [7:0] OP_MOV_IND_A = 8'hf6;
    localparam logic [7:0] OP_MOV_IND_DIR = 8'ha6;
    localparam logic [7:0] OP_MOV_IND_IMM = 8'h76;
    localparam logic [7:0] OP_LOAD_DP = 8'h90;
    localparam logic [7:0] OP_CODE_DP = 8'h93;
    localparam logic [7:0] OP_CODE_PC = 8'h83;
    localparam logic [7:0] OP_EXT_RD_PTR = 8'he2;
    localparam logic [7:0] OP_EXT_WR_PTR = 8'hf2;
    localparam logic [7:0] OP_EXT_RD_DP = 8'he0;
    localparam logic [7:0] OP_EXT_WR_DP = 8'hf0;
    localparam logic [7:0] OP_PUSH = 8'hc0;
    localparam logic [7:0] OP_POP = 8'hd0;
    localparam logic [7:0] OP_XCH_REG = 8'hc8;
    localparam logic [7:0] OP_XCH_DIR = 8'hc5;
    localparam logic [7:0] OP_XCH_IND = 8'hc6;
    localparam logic [7:0] OP_XCH_NIB = 8'hd6;
    localparam logic [7:0] OP_CLR_C = 8'hc3;
    localparam logic [7:0] OP_SET_C = 8'hd3;
    localparam logic [7:0] OP_CPL_C = 8'hb3;
    localparam logic [7:0] OP_CLR_BIT = 8'hc2;
    localparam logic [7:0] OP_SET_BIT = 8'hd2;
    localparam logic [7:0] OP_CPL_BIT = 8'hb2;
    localparam logic [7:0] OP_AND_C_BIT = 8'h82;
    localparam logic [7:0] OP_AND_C_NBIT = 8'hb0;
    localparam logic [7:0] OP_OR_C_BIT = 8'h72;
    localparam logic [7:0] OP_OR_C_NBIT = 8'ha0;
    localparam logic [7:0] OP_MOV_C_BIT = 8'ha2;
    localparam logic [7:0] OP_MOV_BIT_C = 8'h92;
    localparam logic [7:0] OP_JMP_C = 8'h40;
    localparam logic [7:0] OP_JMP_NC = 8'h50;
    localparam logic [7:0] OP_JMP_Z = 8'h60;
    localparam logic [7:0] OP_JMP_NZ = 8'h70;
    localparam logic [7:0] OP_JMP_B = 8'h20;
    localparam logic [7:0] OP_JMP_NB = 8'h30;
    localparam logic [7:0] OP_JMP_BC = 8'h10;
    localparam logic [7:0] OP_CALL_ABS = 8'h11;
    localparam logic [7:0] OP_CALL_LONG = 8'h12;
    localparam logic [7:0] OP_RET = 8'h22;
    localparam logic [7:0] OP_RETI = 8'h32;
    localparam logic [7:0] OP_JMP_ABS = 8'h01;
    localparam logic [7:0] OP_JMP_LONG = 8'h02;
    localparam logic [7:0] OP_JMP_SHORT = 8'h80;
    localparam logic [7:0] OP_JMP_IND = 8'h73;
    localparam logic [7:0] OP_CMP_DIR = 8'hb5;
    localparam logic [7:0] OP_CMP_IMM = 8'hb4;
    localparam logic [7:0] OP_CMP_REG = 8'hb8;
    localparam logic [7:0] OP_CMP_IND = 8'hb6;
    localparam logic [7:0] OP_DEC_REG = 8'hd8;
    localparam logic [7:0] OP_DEC_DIR = 8'hd5;
    // Branch condition kinds.
    typedef enum logic [3:0] {
        CND_NONE = 4'h0, CND_C_SET = 4'h1, CND_C_CLR = 4'h2, CND_A_ZERO = 4'h3,
        CND_A_NZ = 4'h4, CND_BIT_SET = 4'h5, CND_BIT_CLR = 4'h6,
        CND_BIT_SET_CLR = 4'h7, CND_UNEQUAL = 4'h8, CND_DEC_NZ = 4'h9
    } ict_cond_t;
    typedef struct packed {
        logic known;
        logic nibble;
        ict_cond_t cond;
        logic [1:0] len;
        logic [2:0] base;
    } ict_dec_t;
    typedef enum logic [1:0] {ST_READY = 2'h1, ST_BUSY = 2'h2} ict_state_t;
endpackage

//--- src/ict_seq_if.sv
`timescale 1ns/1ps
interface ict_seq_if;
    logic start;
    logic [2:0] total;
    logic ready;
    logic done;
    modport core (output start, output total, input ready, input done);
    modport seq (input start, input total, output ready, output done);
endinterface

//--- src/ict_cycle_seq.sv
`timescale 1ns/1ps
module ict_cycle_seq (
    input wire logic clock_in,
    input wire logic resetn_in,
    ict_seq_if.seq seq_if
);
    import ict_pkg::*;

    ict_state_t state_q;
    ict_state_t state_d;
    logic [2:0] remain_q;
    logic ready_q;
    logic done_q;

    assign seq_if.ready = ready_q;
    assign seq_if.done = done_q;

    // Next state: a start only counts while ready, so no instruction overlaps another.
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_READY:
                if (seq_if.start && seq_if.total != CYC_1)
                    state_d = ST_BUSY;
            ST_BUSY:
                if (remain_q == CNT_LAST)
                    state_d = ST_READY;
            default:
                state_d = ST_READY;
        endcase
    end

    // State and ready flop; ready is registered so the fetch side sees no glitch.
    // hold next fetch.
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state_q <= ST_READY;
            ready_q <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            ready_q <= (state_d == ST_READY);
        end
    end

    // Remaining cycles of the running instruction.
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
            remain_q <= CNT_LAST;
        else if (state_q == ST_READY && seq_if.start)
            remain_q <= seq_if.total - CNT_LAST;
        else if (state_q == ST_BUSY)
            remain_q <= remain_q - CNT_LAST;
    end

    // Completion pulse, in the cycle in which ready comes back.
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
            done_q <= 1'b0;
        else
            done_q <= (state_q == ST_READY && seq_if.start && seq_if.total == CYC_1) ||
                      (state_q == ST_BUSY && remain_q == CNT_LAST);
    end
endmodule // ict_cycle_seq

//--- src/ict_cycle_timer.sv
// Overview of operation
// - Direct or immediate into register: 2 bytes, 2 cycles.
// - Direct-to-direct, immediate-to-direct: 3 bytes, 3 cycles.
// - Accumulator into indirect RAM: 1 byte, 2 cycles.
// - Other indirect RAM moves: 2 bytes, 2 cycles.
// - Load data pointer constant: 3 bytes, 3 cycles.
// - Both code byte loads: 1 byte, 3 cycles.
// - All external space moves: 1 byte, 3 cycles.
// - Push and pop: 2 bytes, 2 cycles.
// - Exchange register 1 cycle, others 2.
// - Low nibble exchange: 1 byte, 2 cycles.
// - Carry ops 1/1; direct bit ops 2/2.
// - Carry or accumulator jumps: 2 bytes, 2/3.
// - Bit jumps 3 bytes 3/4; clear-variant clears.
// - Compare jumps 3/4, indirect form 4/5.
// - Decrement jumps: register 2/3, direct 3/4.
// - Short and page jumps 3, long 4.
// - Indirect jump: 1 byte, 3 cycles.
// - Not taken uses lower count, taken adds one.
`timescale 1ns/1ps
module ict_cycle_timer (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic opcode_valid_in,
    input wire logic [7:0] opcode_in,
    input wire logic carry_in,
    input wire logic acc_zero_in,
    input wire logic bit_value_in,
    input wire logic operands_unequal_in,
    input wire logic dec_result_nonzero_in,
    output logic fetch_ready_out,
    output logic instr_done_out,
    output logic [1:0] instr_length_out,
    output logic [2:0] instr_cycles_out,
    output logic branch_taken_out,
    output logic bit_clear_out,
    output logic low_nibble_only_out,
    output logic opcode_known_out
);
    import ict_pkg::*;

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!resetn_in);

    ict_seq_if seq_bus();
    ict_dec_t dec_w;
    logic [2:0] base_w;
    logic [2:0] total_w;
    logic met_w;
    logic accept_w;
    logic [1:0] len_q;
    logic [2:0] cyc_q;
    logic taken_q;
    logic clear_q;
    logic nibble_q;
    logic known_q;
    logic [2:0] since_q;

    // True when the opcode falls in a register, pointer or page group.
    function automatic logic is_op(input logic [7:0] op, input logic [7:0] base,
                                   input logic [7:0] mask);
        is_op = ((op & mask) == base);
    endfunction

    // Builds a known descriptor.
    function automatic ict_dec_t mk(input logic [1:0] len, input logic [2:0] cyc,
                                    input ict_cond_t cnd);
        ict_dec_t d;
        d = '0;
        d.known = 1'b1;
        d.len = len;
        d.base = cyc;
        d.cond = cnd;
        mk = d;
    endfunction

    // Opcode to length, base cycles and branch condition.
    function automatic ict_dec_t decode(input logic [7:0] op);
        ict_dec_t d;
        d = mk(LEN_1, CYC_1, CND_NONE);
        d.known = 1'b0;
        if (op == OP_NOP || op == OP_SPARE || is_op(op, OP_MOV_REG_A, M_REG) ||
            op == OP_CLR_C || op == OP_SET_C || op == OP_CPL_C ||
            is_op(op, OP_XCH_REG, M_REG))
            d = mk(LEN_1, CYC_1, CND_NONE);
        else if (is_op(op, OP_MOV_REG_DIR, M_REG) || is_op(op, OP_MOV_REG_IMM, M_REG) ||
                 op == OP_MOV_A_IMM || op == OP_MOV_DIR_A ||
                 is_op(op, OP_MOV_DIR_REG, M_REG))
            d = mk(LEN_2, CYC_2, CND_NONE);
        else if (op == OP_MOV_DIR_DIR || op == OP_MOV_DIR_IMM || op == OP_LOAD_DP)
            d = mk(LEN_3, CYC_3, CND_NONE);
        else if (is_op(op, OP_MOV_IND_A, M_PTR) || is_op(op, OP_XCH_IND, M_PTR))
            d = mk(LEN_1, CYC_2, CND_NONE);
        else if (is_op(op, OP_XCH_NIB, M_PTR))
        begin
            d = mk(LEN_1, CYC_2, CND_NONE);
            d.nibble = 1'b1;
        end
        else if (is_op(op, OP_MOV_DIR_IND, M_PTR) || is_op(op, OP_MOV_IND_DIR, M_PTR) ||
                 is_op(op, OP_MOV_IND_IMM, M_PTR) || op == OP_PUSH || op == OP_POP ||
                 op == OP_XCH_DIR)
            d = mk(LEN_2, CYC_2, CND_NONE);
        else if (op == OP_CODE_DP || op == OP_CODE_PC || op == OP_EXT_RD_DP ||
                 op == OP_EXT_WR_DP || is_op(op, OP_EXT_RD_PTR, M_PTR) ||
                 is_op(op, OP_EXT_WR_PTR, M_PTR) || op == OP_JMP_IND)
            d = mk(LEN_1, CYC_3, CND_NONE);
        else if (op == OP_CLR_BIT || op == OP_SET_BIT || op == OP_CPL_BIT ||
                 op == OP_AND_C_BIT || op == OP_AND_C_NBIT || op == OP_OR_C_BIT ||
                 op == OP_OR_C_NBIT || op == OP_MOV_C_BIT || op == OP_MOV_BIT_C)
            d = mk(LEN_2, CYC_2, CND_NONE);
        else if (op == OP_JMP_C)
            d = mk(LEN_2, CYC_2, CND_C_SET);
        else if (op == OP_JMP_NC)
            d = mk(LEN_2, CYC_2, CND_C_CLR);
        else if (op == OP_JMP_Z)
            d = mk(LEN_2, CYC_2, CND_A_ZERO);
        else if (op == OP_JMP_NZ)
            d = mk(LEN_2, CYC_2, CND_A_NZ);
        else if (op == OP_JMP_B)
            d = mk(LEN_3, CYC_3, CND_BIT_SET);
        else if (op == OP_JMP_NB)
            d = mk(LEN_3, CYC_3, CND_BIT_CLR);
        else if (op == OP_JMP_BC)
            d = mk(LEN_3, CYC_3, CND_BIT_SET_CLR);
        else if (op == OP_CMP_DIR || op == OP_CMP_IMM || is_op(op, OP_CMP_REG, M_REG))
            d = mk(LEN_3, CYC_3, CND_UNEQUAL);
        else if (is_op(op, OP_CMP_IND, M_PTR))
            d = mk(LEN_3, CYC_4, CND_UNEQUAL);
        else if (is_op(op, OP_DEC_REG, M_REG))
            d = mk(LEN_2, CYC_2, CND_DEC_NZ);
        else if (op == OP_DEC_DIR)
            d = mk(LEN_3, CYC_3, CND_DEC_NZ);
        else if (op == OP_JMP_SHORT || is_op(op, OP_JMP_ABS, M_PAGE) ||
                 is_op(op, OP_CALL_ABS, M_PAGE))
            d = mk(LEN_2, CYC_3, CND_NONE);
        else if (op == OP_JMP_LONG || op == OP_CALL_LONG)
            d = mk(LEN_3, CYC_4, CND_NONE);
        else if (op == OP_RET || op == OP_RETI)
            d = mk(LEN_1, CYC_5, CND_NONE);
        decode = d;
    endfunction

    // Branch outcome from the datapath flags sampled with the opcode.
    function automatic logic cond_met(input ict_cond_t cnd, input logic c, input logic z,
                                      input logic b, input logic ne, input logic nz);
        case (cnd)
            CND_C_SET: cond_met = c;
            CND_C_CLR: cond_met = !c;
            CND_A_ZERO: cond_met = z;
            CND_A_NZ: cond_met = !z;
            CND_BIT_SET: cond_met = b;
            CND_BIT_CLR: cond_met = !b;
            CND_BIT_SET_CLR: cond_met = b;
            CND_UNEQUAL: cond_met = ne;
            CND_DEC_NZ: cond_met = nz;
            default: cond_met = 1'b0;
        endcase
    endfunction

    // Decode and duration; a taken branch costs one more cycle than the listed lower count.
    assign dec_w = decode(opcode_in);
    assign base_w = dec_w.base;
    assign met_w = cond_met(dec_w.cond, carry_in, acc_zero_in, bit_value_in,
                            operands_unequal_in, dec_result_nonzero_in);
    assign total_w = met_w ? base_w + CYC_EXTRA : base_w;
    assign accept_w = opcode_valid_in && seq_bus.ready;
    assign seq_bus.start = accept_w;
    assign seq_bus.total = total_w;

    ict_cycle_seq u_seq (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .seq_if(seq_bus)
    );

    // Descriptor of the running instruction, held until the next accept.
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            len_q <= LEN_1;
            cyc_q <= CYC_1;
            nibble_q <= 1'b0;
            known_q <= 1'b0;
        end
        else if (accept_w)
        begin
            len_q <= dec_w.len;
            cyc_q <= total_w;
            nibble_q <= dec_w.nibble;
            known_q <= dec_w.known;
        end
    end

    // Branch outcome, and a one-cycle clear request for the bit test that found it set.
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            taken_q <= 1'b0;
            clear_q <= 1'b0;
        end
        else
        begin
            if (accept_w)
                taken_q <= met_w;
            clear_q <= accept_w && dec_w.cond == CND_BIT_SET_CLR && bit_value_in;
        end
    end

    assign fetch_ready_out = seq_bus.ready;
    assign instr_done_out = seq_bus.done;
    assign instr_length_out = len_q;
    assign instr_cycles_out = cyc_q;
    assign branch_taken_out = taken_q;
    assign bit_clear_out = clear_q;
    assign low_nibble_only_out = nibble_q;
    assign opcode_known_out = known_q;

    // Cycles since the last accept, saturating; read only by the checks below.
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
            since_q <= CYC_1;
        else if (accept_w)
            since_q <= CYC_1;
        else if (since_q != SINCE_MAX)
            since_q <= since_q + CYC_1;
    end

    a_mov_reg_two: assert property (
        accept_w && (is_op(opcode_in, OP_MOV_REG_DIR, M_REG) || opcode_in == OP_MOV_A_IMM)
        |=> instr_length_out == LEN_2 && instr_cycles_out == CYC_2 ##1 fetch_ready_out)
        else $error("Two byte move timing wrong.");
    a_mov_dir_three: assert property (
        accept_w && (opcode_in == OP_MOV_DIR_DIR || opcode_in == OP_MOV_DIR_IMM)
        |=> instr_length_out == LEN_3 && !fetch_ready_out [*2] ##1 fetch_ready_out)
        else $error("Three byte move timing wrong.");
    a_ind_store_time: assert property (
        accept_w && is_op(opcode_in, OP_MOV_IND_A, M_PTR)
        |=> instr_length_out == LEN_1 && !fetch_ready_out ##1 fetch_ready_out)
        else $error("Indirect store timing wrong.");
    a_ind_move_time: assert property (
        accept_w && is_op(opcode_in, OP_MOV_DIR_IND, M_PTR)
        |=> instr_length_out == LEN_2 && instr_cycles_out == CYC_2)
        else $error("Indirect move timing wrong.");
    a_dp_load_time: assert property (
        accept_w && opcode_in == OP_LOAD_DP
        |=> instr_length_out == LEN_3 && instr_cycles_out == CYC_3)
        else $error("Data pointer load timing wrong.");
    a_code_load_wait: assert property (
        accept_w && (opcode_in == OP_CODE_DP || opcode_in == OP_CODE_PC)
        |=> !fetch_ready_out [*2] ##1 fetch_ready_out && instr_done_out)
        else $error("Code byte load timing wrong.");
    a_ext_move_time: assert property (
        accept_w && (is_op(opcode_in, OP_EXT_WR_PTR, M_PTR) || opcode_in == OP_EXT_RD_DP)
        |=> instr_length_out == LEN_1 && instr_cycles_out == CYC_3)
        else $error("External space move timing wrong.");
    a_stack_op_time: assert property (
        accept_w && (opcode_in == OP_PUSH || opcode_in == OP_POP)
        |=> instr_length_out == LEN_2 && instr_cycles_out == CYC_2)
        else $error("Stack operation timing wrong.");
    a_xch_cycles: assert property (
        accept_w && (is_op(opcode_in, OP_XCH_REG, M_REG) || opcode_in == OP_XCH_DIR)
        |=> instr_cycles_out == (is_op($past(opcode_in), OP_XCH_REG, M_REG) ? CYC_1 : CYC_2))
        else $error("Exchange timing wrong.");
    a_nibble_xch: assert property (
        accept_w && is_op(opcode_in, OP_XCH_NIB, M_PTR)
        |=> low_nibble_only_out && instr_length_out == LEN_1 && instr_cycles_out == CYC_2)
        else $error("Nibble exchange wrong.");
    a_carry_op_time: assert property (
        accept_w && (opcode_in == OP_CLR_C || opcode_in == OP_CPL_C)
        |=> instr_length_out == LEN_1 && fetch_ready_out && instr_done_out)
        else $error("Carry operation timing wrong.");
    a_carry_jump: assert property (
        accept_w && opcode_in == OP_JMP_C
        |=> branch_taken_out == $past(carry_in) &&
            instr_cycles_out == (branch_taken_out ? CYC_3 : CYC_2))
        else $error("Carry jump timing wrong.");
    a_bit_clear: assert property (
        accept_w && opcode_in == OP_JMP_BC
        |=> bit_clear_out == $past(bit_value_in) && instr_length_out == LEN_3 &&
            instr_cycles_out == (bit_clear_out ? CYC_4 : CYC_3))
        else $error("Bit test clear jump wrong.");
    a_cmp_ind_time: assert property (
        accept_w && is_op(opcode_in, OP_CMP_IND, M_PTR)
        |=> branch_taken_out == $past(operands_unequal_in) &&
            instr_cycles_out == (branch_taken_out ? CYC_5 : CYC_4))
        else $error("Indirect compare jump timing wrong.");
    a_dec_dir_time: assert property (
        accept_w && opcode_in == OP_DEC_DIR
        |=> instr_length_out == LEN_3 && branch_taken_out == $past(dec_result_nonzero_in) &&
            instr_cycles_out == (branch_taken_out ? CYC_4 : CYC_3))
        else $error("Decrement jump timing wrong.");
    a_long_jump: assert property (
        accept_w && opcode_in == OP_JMP_LONG
        |=> !fetch_ready_out [*3] ##1 fetch_ready_out)
        else $error("Long jump timing wrong.");
    a_ind_jump: assert property (
        accept_w && opcode_in == OP_JMP_IND
        |=> instr_length_out == LEN_1 && instr_cycles_out == CYC_3)
        else $error("Indirect jump timing wrong.");
    a_branch_extra: assert property (
        accept_w && dec_w.cond != CND_NONE
        |=> instr_cycles_out == (branch_taken_out ? $past(base_w) + CYC_EXTRA : $past(base_w)))
        else $error("Branch extra cycle wrong.");
    a_fetch_spacing: assert property (
        $rose(fetch_ready_out) |-> since_q == instr_cycles_out)
        else $error("Fetch released at wrong cycle.");
    a_short_jump: assert property (
        accept_w && opcode_in == OP_JMP_SHORT
        |=> (instr_length_out == LEN_2 && !fetch_ready_out) [*2] ##1 fetch_ready_out)
        else $error("Short jump timing wrong.");
    a_acc_jump: assert property (
        accept_w && opcode_in == OP_JMP_NZ
        |=> branch_taken_out == !$past(acc_zero_in) && instr_length_out == LEN_2)
        else $error("Accumulator jump outcome wrong.");
    a_dec_reg_time: assert property (
        accept_w && is_op(opcode_in, OP_DEC_REG, M_REG)
        |=> instr_length_out == LEN_2 && branch_taken_out == $past(dec_result_nonzero_in) &&
            instr_cycles_out == (branch_taken_out ? CYC_3 : CYC_2))
        else $error("Register decrement jump timing wrong.");
endmodule // ict_cycle_timer

//--- verification/ict_mem_model.sv
`timescale 1ns/1ps
// Memory side: offers one opcode and the datapath flags for each fetch.
module ict_mem_model (
    input wire logic clock_in,
    input wire logic offer_in,
    input wire logic [7:0] op_in,
    input wire logic [4:0] flags_in,
    output logic valid_out,
    output logic [7:0] op_out,
    output logic [4:0] flags_out
);
    logic [7:0] junk_q = 8'h5a;
    // Idle lines keep changing, so a stale opcode is never taken for a fresh one.
    always @(negedge clock_in)
        junk_q <= ~junk_q + 8'h01;
    assign valid_out = offer_in;
    assign op_out = offer_in ? op_in : junk_q;
    assign flags_out = offer_in ? flags_in : junk_q[4:0];
endmodule // ict_mem_model

//--- verification/ict_cycle_timer_tb.sv
`timescale 1ns/1ps
module ict_cycle_timer_tb;
    import ict_pkg::*;
    logic clock_in = 1'b0;
    logic resetn_in = 1'b0;
    logic offer = 1'b0;
    logic [7:0] op = 8'h00;
    logic [4:0] fl = 5'h00;
    logic valid, ready, done, taken, clr, nib, known;
    logic [7:0] opc;
    logic [4:0] f;
    logic [1:0] len;
    logic [2:0] cyc;
    int err_count = 0;
    int checks = 0;
    // Free-running 100 MHz clock.
    always #5 clock_in = ~clock_in;
    ict_mem_model i_ict_mem_model (.clock_in(clock_in), .offer_in(offer), .op_in(op),
        .flags_in(fl), .valid_out(valid), .op_out(opc), .flags_out(f));
    ict_cycle_timer i_ict_cycle_timer (.clock_in(clock_in), .resetn_in(resetn_in),
        .opcode_valid_in(valid), .opcode_in(opc), .carry_in(f[4]), .acc_zero_in(f[3]),
        .bit_value_in(f[2]), .operands_unequal_in(f[1]), .dec_result_nonzero_in(f[0]),
        .fetch_ready_out(ready), .instr_done_out(done), .instr_length_out(len),
        .instr_cycles_out(cyc), .branch_taken_out(taken), .bit_clear_out(clr),
        .low_nibble_only_out(nib), .opcode_known_out(known));
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    function automatic logic [6:0] k(input logic [1:0] l, input logic [2:0] c, input logic t);
        return {1'b1, l, c, t};
    endfunction
    // Expected {known, length, lower cycle count, taken}; flags are {c, z, bit, ne, nz}.
    function automatic logic [6:0] ex(input logic [7:0] o, input logic [4:0] v);
        casez (o)
            8'b1111_1???, 8'b1100_1???, 8'hc3, 8'hd3, 8'hb3, 8'h00, 8'ha5: ex = k(2'h1, 3'h1, 1'b0);
            8'b1010_1???, 8'b0111_1???, 8'h74, 8'hf5, 8'b1000_1???, 8'b1000_011?, 8'b1010_011?,
            8'b0111_011?, 8'hc0, 8'hd0, 8'hc5, 8'hc2, 8'hd2, 8'hb2, 8'h82, 8'hb0, 8'h72, 8'ha0,
            8'ha2, 8'h92: ex = k(2'h2, 3'h2, 1'b0);
            8'h85, 8'h75, 8'h90: ex = k(2'h3, 3'h3, 1'b0);
            8'b1111_011?, 8'b1100_011?, 8'b1101_011?: ex = k(2'h1, 3'h2, 1'b0);
            8'h93, 8'h83, 8'b1110_001?, 8'b1111_001?, 8'he0, 8'hf0, 8'h73: ex = k(2'h1, 3'h3, 1'b0);
            8'h22, 8'h32: ex = k(2'h1, 3'h5, 1'b0);
            8'b????0001, 8'h80: ex = k(2'h2, 3'h3, 1'b0);
            8'h02, 8'h12: ex = k(2'h3, 3'h4, 1'b0);
            8'h40: ex = k(2'h2, 3'h2, v[4]);
            8'h50: ex = k(2'h2, 3'h2, !v[4]);
            8'h60: ex = k(2'h2, 3'h2, v[3]);
            8'h70: ex = k(2'h2, 3'h2, !v[3]);
            8'b1101_1???: ex = k(2'h2, 3'h2, v[0]);
            8'h20, 8'h10: ex = k(2'h3, 3'h3, v[2]);
            8'h30: ex = k(2'h3, 3'h3, !v[2]);
            8'hb4, 8'hb5, 8'b1011_1???: ex = k(2'h3, 3'h3, v[1]);
            8'hd5: ex = k(2'h3, 3'h3, v[0]);
            8'b1011_011?: ex = k(2'h3, 3'h4, v[1]);
            default: ex = {1'b0, LEN_1, CYC_1, 1'b0};
        endcase
    endfunction
    task automatic run(input logic [7:0] o, input logic [4:0] v);
        logic [6:0] e;
        int n;
        e = ex(o, v);
        n = e[3:1] + e[0];
        op = o;
        fl = v;
        offer = 1'b1;
        @(posedge clock_in);
        for (int i = 1; i <= n; i++)
        begin
            @(negedge clock_in);
            if (i == 1)
            begin
                chk("len", len, e[5:4]);
                chk("cycles", cyc, n[2:0]);
                chk("taken", taken, e[0]);
                chk("known", known, e[6]);
                chk("nibble", nib, o[7:1] == 7'h6b);
            end
            // The clear request is a single pulse, so it is checked in every cycle.
            chk("clear", clr, i == 1 && o == 8'h10 && v[2]);
            chk("ready", ready, i == n);
            chk("done", done, i == n);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog cuts a hang short.
    initial
    begin
        #400000;
        err_count++;
        final_report;
    end
    // Reset, corner cases, every opcode, then random traffic.
    initial
    begin
        void'($urandom(45));
        repeat (8) @(negedge clock_in);
        resetn_in = 1'b1;
        chk("ready", ready, 8'h01);
        chk("cycles", cyc, 8'h01);
        $display("test reset done");
        run(8'hf8, 5'h00);
        run(8'hc9, 5'h00);
        run(8'h10, 5'h04);
        run(8'hb6, 5'h02);
        run(8'hb6, 5'h00);
        $display("test corners done");
        // A reset in the middle of a five-cycle instruction must free the fetch at once.
        op = 8'h22;
        @(posedge clock_in);
        @(negedge clock_in);
        chk("ready", ready, 8'h00);
        resetn_in = 1'b0;
        @(negedge clock_in);
        chk("ready", ready, 8'h01);
        chk("done", done, 8'h00);
        chk("known", known, 8'h00);
        resetn_in = 1'b1;
        $display("test mid reset done");
        for (int i = 0; i < 256; i++)
            run(i[7:0], 5'($urandom));
        for (int i = 0; i < 400; i++)
            run(8'($urandom), 5'($urandom));
        $display("test random done");
        offer = 1'b0;
        final_report;
    end
endmodule // ict_cycle_timer_tb
